/* oscst_pkg.sv */
/*
  Shared constants for the crystal oscillation stabilization counter:
  register addresses, reset values, field positions and the wait thresholds.
  Assumes a 16-bit special function register address space with 8-bit data.
*/
package oscst_pkg;

  // Register addresses in the special function register space.
  localparam logic [15:0] ADDR_MAIN_OSC_CONTROL = 16'hFFA2;
  localparam logic [15:0] ADDR_STAB_STATUS      = 16'hFFA3;
  localparam logic [15:0] ADDR_STAB_WAIT_SELECT = 16'hFFA4;

  // Reset values.
  localparam logic [7:0] RST_MAIN_OSC_CONTROL = 8'h80;
  localparam logic [7:0] RST_STAB_STATUS      = 8'h00;
  localparam logic [2:0] RST_WAIT_SEL         = 3'h5;

  // Field positions.
  localparam int MAIN_OSC_STOP_BIT = 7;
  localparam int WAIT_SEL_MSB      = 2;
  localparam int STATUS_MSB        = 4;

  // Counter width, enough to hold the longest threshold.
  localparam int CNT_W = 17;

  // Thresholds in crystal clock periods.
  localparam logic [16:0] THR_2P11 = 17'h00800;
  localparam logic [16:0] THR_2P13 = 17'h02000;
  localparam logic [16:0] THR_2P14 = 17'h04000;
  localparam logic [16:0] THR_2P15 = 17'h08000;
  localparam logic [16:0] THR_2P16 = 17'h10000;

  // Wait-select codes.
  localparam logic [2:0] SEL_2P11 = 3'h1;
  localparam logic [2:0] SEL_2P13 = 3'h2;
  localparam logic [2:0] SEL_2P14 = 3'h3;
  localparam logic [2:0] SEL_2P15 = 3'h4;
  localparam logic [2:0] SEL_2P16 = 3'h5;

endpackage

/* oscst_flag.sv */
/*
  One sticky stabilization flag: sets once the crystal cycle count has
  reached its threshold and holds until cleared.
  Assumes count and clear come from logic on clk_sys.
*/
`timescale 1ns/10ps
module oscst_flag #(
  parameter logic [16:0] THRESHOLD = 17'h00800
) (
  // Clock and reset.
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Count and clear.
  input  wire logic [16:0] count,
  input  wire logic        clear,
  // Flag.
  output logic             flag
);

  logic next_flag;

  // Count restarts on clear, so a stale count must not set the flag then.
  always_comb begin
    next_flag = flag;
    if (clear) begin
      next_flag = 1'b0;
    end else if (count >= THRESHOLD) begin
      next_flag = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      flag <= 1'b0;
    end else begin
      flag <= next_flag;
    end
  end

endmodule

/* oscst_top.sv */
/*
  Crystal oscillation stabilization counter with its status register,
  wait-select register and oscillator stop control, on the CPU register port.
  Assumes rst merges every reset source, stop_enter and stop_release are
  one-cycle pulses from the standby logic, and the crystal or external clock
  runs well below half of clk_sys.
*/
`timescale 1ns/10ps
module oscst_top (
  // Clock and reset.
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Register port.
  input  wire logic [15:0] sfr_addr,
  input  wire logic        sfr_wr,
  input  wire logic        sfr_rd,
  input  wire logic [7:0]  sfr_wdata,
  output logic [7:0]       sfr_rdata,
  // Clock source pins and mode.
  input  wire logic        main_crystal_clock,
  input  wire logic        external_clock_in,
  input  wire logic        ext_clk_mode,
  output logic             osc_enable,
  // Standby and CPU clock.
  input  wire logic        stop_enter,
  input  wire logic        stop_release,
  input  wire logic        cpu_on_crystal,
  output logic             cpu_hold
);

  logic                          main_osc_stop;
  logic [2:0]                    wait_sel;
  logic                          in_stop;
  logic [oscst_pkg::CNT_W-1:0]   count;
  logic [4:0]                    status;
  logic                          xtal_s1;
  logic                          xtal_s2;
  logic                          ext_s1;
  logic                          ext_s2;
  logic                          src_sel;
  logic                          src_prev;
  logic                          next_main_osc_stop;
  logic [2:0]                    next_wait_sel;
  logic                          next_in_stop;
  logic [oscst_pkg::CNT_W-1:0]   next_count;
  logic                          next_cpu_hold;
  logic [7:0]                    next_rdata;
  logic [oscst_pkg::CNT_W-1:0]   limit;
  logic                          cnt_edge;
  logic                          clear_evt;
  logic                          wr_moc;
  logic                          wr_sel;

  // Write decodes; the select register keeps only the low three data bits.
  assign wr_moc = sfr_wr && (sfr_addr == oscst_pkg::ADDR_MAIN_OSC_CONTROL);
  assign wr_sel = sfr_wr && (sfr_addr == oscst_pkg::ADDR_STAB_WAIT_SELECT);

  // Clearing events; a reset release is covered by rst itself.
  assign clear_evt = stop_enter || (wr_moc && sfr_wdata[oscst_pkg::MAIN_OSC_STOP_BIT]);

  // The oscillator runs unless stopped by software or by STOP mode.
  assign osc_enable = !main_osc_stop && !in_stop;

  // Synchronise both source pins first; only the second stages are read.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      xtal_s1  <= 1'b0;
      xtal_s2  <= 1'b0;
      ext_s1   <= 1'b0;
      ext_s2   <= 1'b0;
      src_prev <= 1'b0;
    end else begin
      xtal_s1  <= main_crystal_clock;
      xtal_s2  <= xtal_s1;
      ext_s1   <= external_clock_in;
      ext_s2   <= ext_s1;
      src_prev <= src_sel;
    end
  end

  // Picking the source after synchronising keeps the mux off the raw pins.
  assign src_sel = ext_clk_mode ? ext_s2 : xtal_s2;

  // A rising edge is a real crystal period, so start-up delay never counts.
  assign cnt_edge = src_sel && !src_prev && osc_enable;

  // Selected limit; prohibited codes fall back to the longest wait for safety.
  always_comb begin
    unique case (wait_sel)
      oscst_pkg::SEL_2P11: limit = oscst_pkg::THR_2P11;
      oscst_pkg::SEL_2P13: limit = oscst_pkg::THR_2P13;
      oscst_pkg::SEL_2P14: limit = oscst_pkg::THR_2P14;
      oscst_pkg::SEL_2P15: limit = oscst_pkg::THR_2P15;
      default:             limit = oscst_pkg::THR_2P16;
    endcase
  end

  // Next state of control registers, counter and CPU hold.
  always_comb begin
    next_main_osc_stop = main_osc_stop;
    next_wait_sel      = wait_sel;
    next_in_stop       = in_stop;
    next_count         = count;
    next_cpu_hold      = cpu_hold;
    if (wr_moc) begin
      next_main_osc_stop = sfr_wdata[oscst_pkg::MAIN_OSC_STOP_BIT];
    end
    if (wr_sel) begin
      next_wait_sel = sfr_wdata[oscst_pkg::WAIT_SEL_MSB:0];
    end
    if (stop_enter) begin
      next_in_stop = 1'b1;
    end else if (stop_release) begin
      next_in_stop = 1'b0;
    end
    if (clear_evt) begin
      next_count = '0;
    end else if (cnt_edge && (count < limit)) begin
      next_count = count + 1'b1;
    end
    if (stop_release && in_stop && cpu_on_crystal) begin
      next_cpu_hold = 1'b1;
    end else if (count >= limit) begin
      next_cpu_hold = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      main_osc_stop <= oscst_pkg::RST_MAIN_OSC_CONTROL[oscst_pkg::MAIN_OSC_STOP_BIT];
      wait_sel      <= oscst_pkg::RST_WAIT_SEL;
      in_stop       <= 1'b0;
      count         <= '0;
      cpu_hold      <= 1'b0;
    end else begin
      main_osc_stop <= next_main_osc_stop;
      wait_sel      <= next_wait_sel;
      in_stop       <= next_in_stop;
      count         <= next_count;
      cpu_hold      <= next_cpu_hold;
    end
  end

  // Sticky status flags, bit four for the shortest threshold.
  oscst_flag #(.THRESHOLD(oscst_pkg::THR_2P11)) u_f11 (
    .clk_sys(clk_sys), .rst(rst), .count(count), .clear(clear_evt), .flag(status[4]));
  oscst_flag #(.THRESHOLD(oscst_pkg::THR_2P13)) u_f13 (
    .clk_sys(clk_sys), .rst(rst), .count(count), .clear(clear_evt), .flag(status[3]));
  oscst_flag #(.THRESHOLD(oscst_pkg::THR_2P14)) u_f14 (
    .clk_sys(clk_sys), .rst(rst), .count(count), .clear(clear_evt), .flag(status[2]));
  oscst_flag #(.THRESHOLD(oscst_pkg::THR_2P15)) u_f15 (
    .clk_sys(clk_sys), .rst(rst), .count(count), .clear(clear_evt), .flag(status[1]));
  oscst_flag #(.THRESHOLD(oscst_pkg::THR_2P16)) u_f16 (
    .clk_sys(clk_sys), .rst(rst), .count(count), .clear(clear_evt), .flag(status[0]));

  // Read data; writes to the status register are ignored.
  always_comb begin
    next_rdata = sfr_rdata;
    if (sfr_rd) begin
      unique case (sfr_addr)
        oscst_pkg::ADDR_MAIN_OSC_CONTROL: next_rdata = {main_osc_stop, 7'h00};
        oscst_pkg::ADDR_STAB_STATUS:      next_rdata = {3'h0, status};
        oscst_pkg::ADDR_STAB_WAIT_SELECT: next_rdata = {5'h00, wait_sel};
        default:                          next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sfr_rdata <= oscst_pkg::RST_STAB_STATUS;
    end else begin
      sfr_rdata <= next_rdata;
    end
  end

  // Checks on the behaviour above.
  stop_clears_status_a: assert property (@(posedge clk_sys) disable iff (rst)
    clear_evt |=> (status == 5'h00) && (count == '0))
    else $error("status not cleared by stop event");
  status_order_a: assert property (@(posedge clk_sys) disable iff (rst)
    status inside {5'h00, 5'h10, 5'h18, 5'h1C, 5'h1E, 5'h1F})
    else $error("status bits out of order");
  status_sticky_a: assert property (@(posedge clk_sys) disable iff (rst)
    (status[4] && !clear_evt) |=> status[4])
    else $error("status bit dropped without clear");
  thr_sets_flag_a: assert property (@(posedge clk_sys) disable iff (rst)
    ((count >= oscst_pkg::THR_2P11) && !clear_evt) |=> status[4])
    else $error("first threshold flag late");
  status_upper_zero_a: assert property (@(posedge clk_sys) disable iff (rst)
    ($past(sfr_rd) && ($past(sfr_addr) == oscst_pkg::ADDR_STAB_STATUS))
      |-> (sfr_rdata[7:5] == 3'h0) && (sfr_rdata[4:0] == $past(status)))
    else $error("status read wrong");
  count_limit_a: assert property (@(posedge clk_sys) disable iff (rst)
    count <= limit)
    else $error("counter passed selected limit");
  select_reset_a: assert property (@(posedge clk_sys)
    $past(rst) |-> (wait_sel == oscst_pkg::RST_WAIT_SEL))
    else $error("select not five after reset");
  hold_release_a: assert property (@(posedge clk_sys) disable iff (rst)
    (cpu_hold && (count >= limit) && !(stop_release && in_stop)) |=> !cpu_hold)
    else $error("cpu hold outlasted wait");
  count_edges_a: assert property (@(posedge clk_sys) disable iff (rst)
    (!cnt_edge && !clear_evt) |=> (count == $past(count)))
    else $error("count moved without clock edge");
  hold_set_a: assert property (@(posedge clk_sys) disable iff (rst)
    (stop_release && in_stop && cpu_on_crystal) |=> cpu_hold)
    else $error("cpu hold not raised on release");
  saturate_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
    ((count >= limit) && !clear_evt && !wr_sel) |=> (count == $past(count)))
    else $error("counter moved past its limit");
  reset_clears_a: assert property (@(posedge clk_sys)
    $past(rst) |-> (status == 5'h00) && !cpu_hold && (sfr_rdata == 8'h00))
    else $error("reset did not clear status");

endmodule

/* oscst_xtal_model.sv */
/*
  Behavioural clock source: a crystal that starts late once enabled,
  or an external clock on its own pin.
  Assumes osc_enable comes from the block and ext_mode picks the pin.
*/
`timescale 1ns/10ps
module oscst_xtal_model #(
  parameter int HALF_NS  = 15,
  parameter int START_NS = 200
) (
  // Enable and mode.
  input  wire logic osc_enable,
  input  wire logic ext_mode,
  // Clock pins.
  output logic      main_crystal_clock,
  output logic      external_clock_in
);
  logic src;
  // The source stands low while disabled, so no stray edge is counted.
  always begin
    src = 1'b0;
    wait (osc_enable === 1'b1);
    if (!ext_mode) #(START_NS);
    while (osc_enable === 1'b1) begin
      #(HALF_NS) src = ~src;
    end
  end
  // Only the selected pin carries the clock; the other stays low.
  assign main_crystal_clock = src & ~ext_mode;
  assign external_clock_in  = src & ext_mode;
endmodule

/* tb_oscst_top.sv */
/*
  Self-checking bench for the stabilization counter: registers, threshold
  timing, stop control and the hold after STOP release.
  Assumes the partner source runs at about 33 MHz.
*/
`timescale 1ns/10ps
module tb_oscst_top;
  localparam logic [15:0] A_MC = oscst_pkg::ADDR_MAIN_OSC_CONTROL;
  localparam logic [15:0] A_ST = oscst_pkg::ADDR_STAB_STATUS;
  localparam logic [15:0] A_WS = oscst_pkg::ADDR_STAB_WAIT_SELECT;
  logic        clk_sys, rst, sfr_wr, sfr_rd, ext_clk_mode, xtal, xext;
  logic        stop_enter, stop_release, cpu_on_crystal, osc_enable, cpu_hold;
  logic [15:0] sfr_addr;
  logic [7:0]  sfr_wdata, sfr_rdata;
  int          n_fail, n_checks, k;

  oscst_top dut_u (.clk_sys(clk_sys), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .main_crystal_clock(xtal), .external_clock_in(xext), .ext_clk_mode(ext_clk_mode),
    .osc_enable(osc_enable), .stop_enter(stop_enter), .stop_release(stop_release),
    .cpu_on_crystal(cpu_on_crystal), .cpu_hold(cpu_hold));
  oscst_xtal_model src_u (.osc_enable(osc_enable), .ext_mode(ext_clk_mode),
    .main_crystal_clock(xtal), .external_clock_in(xext));

  // A 100 MHz clock.
  always #5 clk_sys = ~clk_sys;

  // Inputs change 1 ns after the edge so the design samples settled values.
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s got %h", $time, msg, got);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    cyc(1);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    cyc(1);
    sfr_wr = 1'b0;
  endtask
  // Read data is registered, so it is valid just after the sampling edge.
  task automatic rchk(input logic [15:0] a, input logic [7:0] exp);
    cyc(1);
    sfr_addr = a;
    sfr_rd = 1'b1;
    cyc(1);
    sfr_rd = 1'b0;
    chk8(sfr_rdata, exp, "read data");
  endtask
  task automatic stop_cycle;
    stop_enter = 1'b1;
    cyc(1);
    stop_enter = 1'b0;
    cyc(1);
    chk8({7'h00, osc_enable}, 8'h00, "enable in stop");
    rchk(A_ST, 8'h00);
    stop_release = 1'b1;
    cyc(1);
    stop_release = 1'b0;
    chk8({7'h00, cpu_hold}, {7'h00, cpu_on_crystal}, "hold after release");
  endtask

  // Reset values, read-only status, fixed bits and select codes 1 to 5 and 7.
  task automatic t_regs;
    rchk(A_ST, 8'h00);
    rchk(A_WS, 8'h05);
    rchk(A_MC, 8'h80);
    rchk(16'hFF00, 8'h00);
    wr(A_ST, 8'hFF);
    rchk(A_ST, 8'h00);
    wr(A_WS, 8'hFF);
    rchk(A_WS, 8'h07);
    for (k = 1; k <= 5; k++) begin
      wr(A_WS, 8'(k));
      rchk(A_WS, 8'(k));
    end
  endtask
  // Shortest wait: flag sets near 2^11 periods, saturates, stop bit clears it.
  task automatic t_short;
    wr(A_WS, 8'h01);
    wr(A_MC, 8'h00);
    chk8({7'h00, osc_enable}, 8'h01, "enable");
    cyc(5900);
    rchk(A_ST, 8'h00);
    cyc(500);
    rchk(A_ST, 8'h10);
    cyc(3000);
    rchk(A_ST, 8'h10);
    wr(A_MC, 8'h80);
    rchk(A_ST, 8'h00);
  endtask
  // Select 2^13: the 2^11 flag comes first, then both stay set.
  task automatic t_order;
    wr(A_WS, 8'h02);
    wr(A_MC, 8'h00);
    cyc(12000);
    rchk(A_ST, 8'h10);
    cyc(13000);
    rchk(A_ST, 8'h18);
  endtask
  // STOP on the crystal holds the CPU for the selected wait. The oscillator is
  // stopped first, since a shorter select under a saturated count would leave
  // the counter above its new limit.
  task automatic t_stop;
    wr(A_MC, 8'h80);
    wr(A_WS, 8'h01);
    wr(A_MC, 8'h00);
    cpu_on_crystal = 1'b1;
    stop_cycle();
    k = 0;
    while (cpu_hold === 1'b1 && k < 8000) begin
      cyc(1);
      k++;
    end
    chk8({7'h00, k > 6100 && k < 6300}, 8'h01, "hold length");
    rchk(A_ST, 8'h10);
  endtask
  // External clock with the CPU elsewhere: no hold, software polls status.
  task automatic t_ext;
    cpu_on_crystal = 1'b0;
    ext_clk_mode = 1'b1;
    stop_cycle();
    cyc(6400);
    rchk(A_ST, 8'h10);
  endtask
  // A reset in mid-run clears status and hold and restores the select.
  task automatic t_reset;
    rst = 1'b1;
    cyc(3);
    rst = 1'b0;
    chk8(sfr_rdata, 8'h00, "read data after reset");
    chk8({7'h00, osc_enable}, 8'h00, "enable after reset");
    chk8({7'h00, cpu_hold}, 8'h00, "hold after reset");
    rchk(A_ST, 8'h00);
    rchk(A_WS, 8'h05);
    rchk(A_MC, 8'h80);
  endtask

  task automatic summarize;
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Main sequence after a three-cycle reset.
  initial begin
    {clk_sys, sfr_wr, sfr_rd, ext_clk_mode, stop_enter, stop_release} = '0;
    {cpu_on_crystal, sfr_addr, sfr_wdata, n_fail, n_checks} = '0;
    rst = 1'b1;
    cyc(3);
    rst = 1'b0;
    t_regs();
    t_short();
    t_order();
    t_stop();
    t_ext();
    t_reset();
    summarize();
  end
  // Watchdog well past the expected run length of about 50000 cycles.
  initial begin
    #800000;
    n_fail++;
    $display("unexpected at %0t: watchdog expired", $time);
    summarize();
  end
endmodule
